// ---- sos_status_output_selector.sv ----
`timescale 1ns/10ps
`default_nettype none
module sos_status_output_selector
  import sos_pkg::*;
(
  input  wire logic                                   clk,
  input  wire logic                                   rst_b,
  input  wire logic                                   cfg_load,
  input  wire logic [7:0]                             out_pair1_function_sel,
  input  wire logic [7:0]                             out_pair2_function_sel,
  input  wire logic [7:0]                             out_pair3_function_sel,
  input  wire logic [7:0]                             analog_ch1_item_sel,
  input  wire logic signed [15:0]                     analog_ch1_gain,
  input  wire logic signed [15:0]                     analog_ch1_bias,
  input  wire logic [1:0]                             analog_ch1_level_sel,
  input  wire logic [7:0]                             analog_ch2_item_sel,
  input  wire logic signed [15:0]                     analog_ch2_gain,
  input  wire logic signed [15:0]                     analog_ch2_bias,
  input  wire logic [1:0]                             analog_ch2_level_sel,
  input  wire logic                                   run_cmd,
  input  wire logic                                   voltage_out,
  input  wire logic                                   freq_output_active,
  input  wire logic                                   dc_injection,
  input  wire logic [15:0]                            out_freq,
  input  wire logic [15:0]                            zero_speed_level,
  input  wire logic                                   freq_agree,
  input  wire logic                                   init_done,
  input  wire logic                                   dc_undervolt,
  input  wire logic                                   output_blocked,
  input  wire logic                                   ref_src_panel,
  input  wire logic                                   run_src_panel,
  input  wire logic                                   fault_active,
  input  wire logic [7:0]                             fault_code,
  input  wire logic                                   minor_fault,
  input  wire logic                                   fault_reset_cmd,
  input  wire logic                                   reverse_run_cmd,
  input  wire logic                                   ext_block_cmd,
  input  wire logic                                   motor2_sel,
  input  wire logic                                   regenerating,
  input  wire logic                                   drive_enable_in,
  input  wire logic [SOS_ITEM_COUNT*SOS_ITEM_W-1:0]   status_monitor_items,
  output logic                                        output_pair_one,
  output logic                                        output_pair_two,
  output logic                                        output_pair_three,
  output logic signed [15:0]                          analog_out_one,
  output logic signed [15:0]                          analog_out_two
);

  // Latched configuration, loaded on cfg_load and reset to factory values.
  logic [7:0]         pair1_sel_reg;
  logic [7:0]         pair2_sel_reg;
  logic [7:0]         pair3_sel_reg;
  logic [7:0]         ch1_item_reg;
  logic signed [15:0] ch1_gain_reg;
  logic signed [15:0] ch1_bias_reg;
  logic [1:0]         ch1_level_reg;
  logic [7:0]         ch2_item_reg;
  logic signed [15:0] ch2_gain_reg;
  logic signed [15:0] ch2_bias_reg;
  logic [1:0]         ch2_level_reg;

  // Registered contact states.
  logic               pair1_reg;
  logic               pair2_reg;
  logic               pair3_reg;

  // Decoded status conditions shared by all three pairs.
  logic               st_during_run;
  logic               st_during_run2;
  logic               st_zero_speed;
  logic               st_ready;
  logic               st_fault;
  logic               pair1_next;
  logic               pair2_next;
  logic               pair3_next;
  logic [16:0]        cond_vec;
  logic signed [15:0] ch1_item_val;
  logic signed [15:0] ch2_item_val;

  // Maps one function code to its status condition; unknown codes give off.
  // Every condition comes in through the argument, so a continuous assignment re-evaluates on each change.
  function automatic logic sos_route(input logic [7:0]  sel,
                                     input logic [16:0] c);
    logic r;
    r = 1'b0;
    case (sel)
      SOS_FN_DURING_RUN:  r = c[0];
      SOS_FN_ZERO_SPEED:  r = c[1];
      SOS_FN_FREQ_AGREE:  r = c[2];
      SOS_FN_READY:       r = c[3];
      SOS_FN_UNDERVOLT:   r = c[4];
      SOS_FN_BLOCKED:     r = c[5];
      SOS_FN_REF_PANEL:   r = c[6];
      SOS_FN_RUN_PANEL:   r = c[7];
      SOS_FN_FAULT:       r = c[8];
      SOS_FN_MINOR_FAULT: r = c[9];
      SOS_FN_FAULT_RESET: r = c[10];
      SOS_FN_REVERSE:     r = c[11];
      SOS_FN_EXT_BLOCK:   r = c[12];
      SOS_FN_MOTOR2:      r = c[13];
      SOS_FN_REGEN:       r = c[14];
      SOS_FN_DURING_RUN2: r = c[15];
      SOS_FN_ENABLED:     r = c[16];
      default:            r = 1'b0;
    endcase
    return r;
  endfunction : sos_route

  // Picks one monitor item by number; numbers beyond the bus read as zero.
  function automatic logic signed [15:0] sos_item(input logic [7:0] sel,
                                                 input logic [SOS_ITEM_COUNT*SOS_ITEM_W-1:0] items);
    logic signed [15:0] v;
    v = 16'sh0000;
    if (sel < 8'(SOS_ITEM_COUNT)) begin
      v = items[sel*SOS_ITEM_W +: SOS_ITEM_W];
    end
    return v;
  endfunction : sos_item

  // Status conditions built from the raw drive signals.
  assign st_during_run  = run_cmd || voltage_out;
  assign st_during_run2 = freq_output_active && !output_blocked && !dc_injection;
  assign st_zero_speed  = out_freq < zero_speed_level;
  assign st_ready       = init_done && !fault_active;
  assign st_fault       = fault_active && (fault_code != SOS_CTRL_BOARD_FAULT_A)
                          && (fault_code != SOS_CTRL_BOARD_FAULT_B);

  // All selectable conditions gathered in one vector, bit order as the route function expects.
  assign cond_vec = {drive_enable_in, st_during_run2, regenerating, motor2_sel, !ext_block_cmd,
                     reverse_run_cmd, fault_reset_cmd, minor_fault, st_fault, run_src_panel,
                     ref_src_panel, output_blocked, dc_undervolt, st_ready, freq_agree,
                     st_zero_speed, st_during_run};

  // Each pair routes the condition its own code names.
  assign pair1_next = sos_route(pair1_sel_reg, cond_vec);
  assign pair2_next = sos_route(pair2_sel_reg, cond_vec);
  assign pair3_next = sos_route(pair3_sel_reg, cond_vec);

  // Item selection for the two analog channels.
  assign ch1_item_val = sos_item(ch1_item_reg, status_monitor_items);
  assign ch2_item_val = sos_item(ch2_item_reg, status_monitor_items);

  // Output pair selections take their factory codes at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pair1_sel_reg <= SOS_PAIR1_SEL_RST;
      pair2_sel_reg <= SOS_PAIR2_SEL_RST;
      pair3_sel_reg <= SOS_PAIR3_SEL_RST;
    end else if (cfg_load) begin
      pair1_sel_reg <= out_pair1_function_sel;
      pair2_sel_reg <= out_pair2_function_sel;
      pair3_sel_reg <= out_pair3_function_sel;
    end
  end

  // Analog channel settings take their factory values at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ch1_item_reg  <= SOS_CH1_ITEM_RST;
      ch1_gain_reg  <= SOS_CH1_GAIN_RST;
      ch1_bias_reg  <= SOS_BIAS_RST;
      ch1_level_reg <= SOS_LEVEL_RST;
      ch2_item_reg  <= SOS_CH2_ITEM_RST;
      ch2_gain_reg  <= SOS_CH2_GAIN_RST;
      ch2_bias_reg  <= SOS_BIAS_RST;
      ch2_level_reg <= SOS_LEVEL_RST;
    end else if (cfg_load) begin
      ch1_item_reg  <= analog_ch1_item_sel;
      ch1_gain_reg  <= analog_ch1_gain;
      ch1_bias_reg  <= analog_ch1_bias;
      ch1_level_reg <= analog_ch1_level_sel;
      ch2_item_reg  <= analog_ch2_item_sel;
      ch2_gain_reg  <= analog_ch2_gain;
      ch2_bias_reg  <= analog_ch2_bias;
      ch2_level_reg <= analog_ch2_level_sel;
    end
  end

  // Contacts are registered so that they never glitch on decode changes.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pair1_reg <= 1'b0;
      pair2_reg <= 1'b0;
      pair3_reg <= 1'b0;
    end else begin
      pair1_reg <= pair1_next;
      pair2_reg <= pair2_next;
      pair3_reg <= pair3_next;
    end
  end

  assign output_pair_one   = pair1_reg;
  assign output_pair_two   = pair2_reg;
  assign output_pair_three = pair3_reg;

  // First analog monitor channel.
  sos_analog_channel u_ch1 (
    .clk         (clk),
    .rst_b       (rst_b),
    .item_value  (ch1_item_val),
    .gain        (ch1_gain_reg),
    .bias        (ch1_bias_reg),
    .level_sel   (ch1_level_reg),
    .analog_code (analog_out_one)
  );

  // Second analog monitor channel.
  sos_analog_channel u_ch2 (
    .clk         (clk),
    .rst_b       (rst_b),
    .item_value  (ch2_item_val),
    .gain        (ch2_gain_reg),
    .bias        (ch2_bias_reg),
    .level_sel   (ch2_level_reg),
    .analog_code (analog_out_two)
  );

endmodule : sos_status_output_selector
`default_nettype wire

// ---- sos_pkg.sv ----
// Contract
// - Three output pairs, defaults run, zero-speed, freq-agree.
// - Code 0: on when run or voltage.
// - Code 37: on only while frequency output.
// - Code 1: on below zero-speed level.
// - Code 6: on after fault-free startup.
// - Code 7: on during DC bus undervoltage.
// - Code 8: on while output stage blocked.
// - Code 9: on when panel gives reference.
// - Code A: on when panel gives run.
// - Code E: any fault except two board faults.
// - Code 10: on during minor fault.
// - Code 11: on while fault reset asserted.
// - Code 1A: on for reverse run command.
// - Code 1B: off while external block asserted.
// - Code 1C: on while motor two selected.
// - Code 1D: on while motor regenerates.
// - Code 38: on while drive enabled.
// - Analog item select, defaults items 2, 3.
// - Linear scale: bias at zero, gain at full.
// - Analog value clamped to maximum level.
// - Level 1 bipolar, level 2 4-20 mA.
package sos_pkg;

  // Output pair function codes.
  localparam logic [7:0] SOS_FN_DURING_RUN   = 8'h00;
  localparam logic [7:0] SOS_FN_ZERO_SPEED   = 8'h01;
  localparam logic [7:0] SOS_FN_FREQ_AGREE   = 8'h02;
  localparam logic [7:0] SOS_FN_READY        = 8'h06;
  localparam logic [7:0] SOS_FN_UNDERVOLT    = 8'h07;
  localparam logic [7:0] SOS_FN_BLOCKED      = 8'h08;
  localparam logic [7:0] SOS_FN_REF_PANEL    = 8'h09;
  localparam logic [7:0] SOS_FN_RUN_PANEL    = 8'h0A;
  localparam logic [7:0] SOS_FN_FAULT        = 8'h0E;
  localparam logic [7:0] SOS_FN_MINOR_FAULT  = 8'h10;
  localparam logic [7:0] SOS_FN_FAULT_RESET  = 8'h11;
  localparam logic [7:0] SOS_FN_REVERSE      = 8'h1A;
  localparam logic [7:0] SOS_FN_EXT_BLOCK    = 8'h1B;
  localparam logic [7:0] SOS_FN_MOTOR2       = 8'h1C;
  localparam logic [7:0] SOS_FN_REGEN        = 8'h1D;
  localparam logic [7:0] SOS_FN_DURING_RUN2  = 8'h37;
  localparam logic [7:0] SOS_FN_ENABLED      = 8'h38;

  // Factory defaults of the three pair selections.
  localparam logic [7:0] SOS_PAIR1_SEL_RST   = 8'h00;
  localparam logic [7:0] SOS_PAIR2_SEL_RST   = 8'h01;
  localparam logic [7:0] SOS_PAIR3_SEL_RST   = 8'h02;

  // Control-board fault codes that the fault output ignores; values are arbitrary.
  localparam logic [7:0] SOS_CTRL_BOARD_FAULT_A = 8'h80;
  localparam logic [7:0] SOS_CTRL_BOARD_FAULT_B = 8'h81;

  // Monitor item bus shape.
  localparam int         SOS_ITEM_W          = 16;
  localparam int         SOS_ITEM_COUNT      = 16;
  localparam int         SOS_SCALE_SHIFT     = 12;

  // Analog full scale: 4096 counts stand for 100 % and for 10 V or 20 mA.
  localparam logic signed [15:0] SOS_FULL_SCALE  = 16'sh1000;
  localparam logic signed [15:0] SOS_NEG_FULL    = -16'sh1000;
  localparam logic signed [15:0] SOS_CURRENT_4MA = 16'sh0333;
  localparam logic signed [15:0] SOS_CURRENT_SPAN = 16'sh0CCD;

  // Analog channel defaults: items, gain 100 % and 50 %, bias 0 %, level 0.
  localparam logic [7:0]         SOS_CH1_ITEM_RST = 8'h02;
  localparam logic [7:0]         SOS_CH2_ITEM_RST = 8'h03;
  localparam logic signed [15:0] SOS_CH1_GAIN_RST = 16'sh1000;
  localparam logic signed [15:0] SOS_CH2_GAIN_RST = 16'sh0800;
  localparam logic signed [15:0] SOS_BIAS_RST     = 16'sh0000;

  // Signal level selections.
  typedef enum logic [1:0] {
    SOS_LEVEL_UNIPOLAR = 2'b00,
    SOS_LEVEL_BIPOLAR  = 2'b01,
    SOS_LEVEL_CURRENT  = 2'b10
  } sos_level_t;
  localparam logic [1:0] SOS_LEVEL_RST = 2'b00;

endpackage : sos_pkg

// ---- sos_analog_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
module sos_analog_channel
  import sos_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic signed [15:0] item_value,
  input  wire logic signed [15:0] gain,
  input  wire logic signed [15:0] bias,
  input  wire logic [1:0]         level_sel,
  output logic signed [15:0]      analog_code
);

  logic signed [17:0] span;
  logic signed [35:0] product;
  logic signed [35:0] scaled;
  logic signed [35:0] lin;
  logic signed [15:0] lo_lim;
  logic signed [15:0] clamped;
  logic signed [35:0] cur_prod;
  logic signed [15:0] level_code;
  logic signed [15:0] analog_code_reg;

  // Straight line through bias at zero and gain at full scale.
  assign span    = 18'(gain) - 18'(bias);
  assign product = 36'(item_value) * 36'(span);
  assign scaled  = product >>> SOS_SCALE_SHIFT;
  assign lin     = scaled + 36'(bias);

  // Bipolar range allows negative levels; the other two stop at zero.
  assign lo_lim  = (level_sel == SOS_LEVEL_BIPOLAR) ? SOS_NEG_FULL : 16'sh0000;
  assign clamped = (lin > 36'(SOS_FULL_SCALE)) ? SOS_FULL_SCALE :
                   (lin < 36'(lo_lim))         ? lo_lim : lin[15:0];

  // Current mode squeezes the unipolar span into 4 mA to 20 mA.
  assign cur_prod   = (36'(clamped) * 36'(SOS_CURRENT_SPAN)) >>> SOS_SCALE_SHIFT;
  assign level_code = (level_sel == SOS_LEVEL_CURRENT) ?
                      16'(cur_prod[15:0] + SOS_CURRENT_4MA) : clamped;

  // The output code comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      analog_code_reg <= 16'sh0000;
    end else begin
      analog_code_reg <= level_code;
    end
  end

  assign analog_code = analog_code_reg;

endmodule : sos_analog_channel
`default_nettype wire

// ---- sos_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module sos_checker
  import sos_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               cfg_load,
  input  wire logic [7:0]         out_pair1_function_sel,
  input  wire logic [7:0]         out_pair2_function_sel,
  input  wire logic [7:0]         out_pair3_function_sel,
  input  wire logic               run_cmd,
  input  wire logic               voltage_out,
  input  wire logic               freq_output_active,
  input  wire logic               dc_injection,
  input  wire logic [15:0]        out_freq,
  input  wire logic [15:0]        zero_speed_level,
  input  wire logic               freq_agree,
  input  wire logic               init_done,
  input  wire logic               dc_undervolt,
  input  wire logic               output_blocked,
  input  wire logic               fault_active,
  input  wire logic [7:0]         fault_code,
  input  wire logic               ext_block_cmd,
  input  wire logic               output_pair_one,
  input  wire logic               output_pair_two,
  input  wire logic               output_pair_three,
  input  wire logic signed [15:0] analog_out_one
);
  logic [7:0] sel1_reg;
  logic [7:0] sel2_reg;
  logic [7:0] sel3_reg;

  // Mirrors of the loaded codes, so each contact can be tied to the cause that its code selects.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel1_reg <= SOS_PAIR1_SEL_RST;
      sel2_reg <= SOS_PAIR2_SEL_RST;
      sel3_reg <= SOS_PAIR3_SEL_RST;
    end else if (cfg_load) begin
      sel1_reg <= out_pair1_function_sel;
      sel2_reg <= out_pair2_function_sel;
      sel3_reg <= out_pair3_function_sel;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Each contact follows its selected cause one edge later.
  a_run_contact: assert property (sel1_reg == 8'h00 |=> output_pair_one == $past(run_cmd | voltage_out))
    else $error("run contact does not follow run or voltage");
  a_run2_gating: assert property (sel1_reg == 8'h37 |=>
    output_pair_one == $past(freq_output_active & !output_blocked & !dc_injection))
    else $error("second run contact wrong");
  a_zero_speed: assert property (sel2_reg == 8'h01 |=> output_pair_two == $past(out_freq < zero_speed_level))
    else $error("zero speed contact wrong");
  a_ready_after_init: assert property (sel2_reg == 8'h06 |=> output_pair_two == $past(init_done & !fault_active))
    else $error("ready contact wrong");
  a_undervolt_follow: assert property (sel1_reg == 8'h07 |=> output_pair_one == $past(dc_undervolt))
    else $error("undervoltage contact wrong");
  a_fault_excluded: assert property (sel1_reg == 8'h0E && !(fault_active && !(fault_code inside {8'h80, 8'h81}))
    |=> !output_pair_one)
    else $error("fault contact on without a counted fault");
  a_ext_block_off: assert property (sel1_reg == 8'h1B |=> output_pair_one == !$past(ext_block_cmd))
    else $error("block contact wrong");
  a_freq_agree_pair: assert property (sel3_reg == 8'h02 |=> output_pair_three == $past(freq_agree))
    else $error("third pair contact wrong");
  a_undoc_held_off: assert property (!(sel3_reg inside {8'h00, 8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0E, 8'h10, 8'h11, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h37, 8'h38}) |=> !output_pair_three)
    else $error("undocumented code drives contact");
  a_analog_clamped: assert property (analog_out_one <= 16'sh1000 && analog_out_one >= -16'sh1000)
    else $error("analog code beyond full scale");

  // Main scenarios reached by the bench.
  c_run_on: cover property (sel1_reg == 8'h00 && output_pair_one);
  c_clamp_hit: cover property (analog_out_one == 16'sh1000);
  c_fault_skip: cover property (sel1_reg == 8'h0E && fault_active && fault_code == 8'h80);
endmodule : sos_checker

bind sos_status_output_selector sos_checker u_chk (.clk, .rst_b, .cfg_load, .out_pair1_function_sel,
  .out_pair2_function_sel, .out_pair3_function_sel, .run_cmd, .voltage_out, .freq_output_active, .dc_injection,
  .out_freq, .zero_speed_level, .freq_agree, .init_done, .dc_undervolt, .output_blocked, .fault_active,
  .fault_code, .ext_block_cmd, .output_pair_one, .output_pair_two, .output_pair_three, .analog_out_one);
`default_nettype wire

// ---- sos_ext_reader.sv ----
`timescale 1ns/10ps
`default_nettype none
module sos_ext_reader
  import sos_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               contact_one,
  input  wire logic               contact_two,
  input  wire logic               contact_three,
  input  wire logic signed [15:0] level_one,
  input  wire logic signed [15:0] level_two,
  output logic [2:0]              contacts_seen,
  output logic signed [15:0]      level_one_seen,
  output logic signed [15:0]      level_two_seen
);
  // The reading equipment scans contacts and analog levels once a clock, like an input card.
  always_ff @(posedge clk) begin
    contacts_seen  <= {contact_three, contact_two, contact_one};
    level_one_seen <= level_one;
    level_two_seen <= level_two;
  end
endmodule : sos_ext_reader
`default_nettype wire

// ---- tb_status_output_selector.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_status_output_selector;
  logic               clk, rst_b, cfg_load;
  logic [7:0]         s1, s2, s3, is1, is2, fcode;
  logic signed [15:0] g1, b1, g2, b2;
  logic [1:0]         l1, l2;
  logic [17:0]        st;
  logic [15:0]        ofreq, zlev;
  logic [255:0]       ibus;
  wire logic          o1, o2, o3;
  wire logic [15:0]   a1, a2, a1s, a2s;
  wire logic [2:0]    cseen;
  int                 n_fail, cmp_count;
  int                 at [8][5] = '{'{5, 2048, 4096, 1024, 0}, '{5, 0, 4096, 1024, 0}, '{5, 4096, 8192, 0, 0},
    '{5, -2048, 4096, 0, 1}, '{5, -2048, 4096, 0, 0}, '{5, 4096, 4096, 0, 2}, '{5, 0, 4096, 0, 2},
    '{9, 1000, 4096, 0, 0}};
  logic [7:0]         dcode [15] = '{8'h00, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E, 8'h10, 8'h11,
    8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h38};
  int                 dbit [15] = '{0, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17};

  sos_status_output_selector u_dut (.clk(clk), .rst_b(rst_b), .cfg_load(cfg_load), .out_pair1_function_sel(s1),
    .out_pair2_function_sel(s2), .out_pair3_function_sel(s3), .analog_ch1_item_sel(is1), .analog_ch1_gain(g1),
    .analog_ch1_bias(b1), .analog_ch1_level_sel(l1), .analog_ch2_item_sel(is2), .analog_ch2_gain(g2),
    .analog_ch2_bias(b2), .analog_ch2_level_sel(l2), .run_cmd(st[0]), .voltage_out(st[1]),
    .freq_output_active(st[2]), .dc_injection(st[3]), .out_freq(ofreq), .zero_speed_level(zlev),
    .freq_agree(st[4]), .init_done(st[5]), .dc_undervolt(st[6]), .output_blocked(st[7]), .ref_src_panel(st[8]),
    .run_src_panel(st[9]), .fault_active(st[10]), .fault_code(fcode), .minor_fault(st[11]),
    .fault_reset_cmd(st[12]), .reverse_run_cmd(st[13]), .ext_block_cmd(st[14]), .motor2_sel(st[15]),
    .regenerating(st[16]), .drive_enable_in(st[17]), .status_monitor_items(ibus), .output_pair_one(o1),
    .output_pair_two(o2), .output_pair_three(o3), .analog_out_one(a1), .analog_out_two(a2));
  sos_ext_reader u_reader (.clk(clk), .contact_one(o1), .contact_two(o2), .contact_three(o3), .level_one(a1),
    .level_two(a2), .contacts_seen(cseen), .level_one_seen(a1s), .level_two_seen(a2s));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic load;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask : load

  task automatic pairs(input string what, input logic [7:0] code, input logic [2:0] exp);
    s1 = code;
    s2 = code;
    s3 = code;
    load;
    settle;
    chk(what, {13'h0, cseen}, {13'h0, exp});
  endtask : pairs

  // Independent reckoning of the scaled, clamped and level-shifted analog code.
  function automatic logic [15:0] exp_an(input int item, input int g, input int b, input int lv);
    int v;
    v = b + ((item * (g - b)) >>> 12);
    if (v > 4096) v = 4096;
    if (v < ((lv == 1) ? -4096 : 0)) v = (lv == 1) ? -4096 : 0;
    if (lv == 2) v = 819 + ((v * 3277) >>> 12);
    return v[15:0];
  endfunction : exp_an

  // Reset zeroes the outputs; afterwards the default codes and monitor items are in force.
  task automatic reset_defaults;
    rst_b = 1'b0;
    st = '1;
    settle;
    chk("reset contacts", {13'h0, cseen}, 16'h0000);
    chk("reset analog", a1s, 16'h0000);
    repeat (7) @(negedge clk);
    rst_b = 1'b1;
    st = 18'h0_0011;
    ofreq = 16'h0000;
    settle;
    chk("default contacts", {13'h0, cseen}, 16'h0007);
    chk("default analog one", a1s, 16'h0800);
    chk("default analog two", a2s, 16'h0800);
    $display("test reset defaults done");
  endtask : reset_defaults

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    n_fail++;
    test_done;
  end

  initial begin
    {rst_b, cfg_load, s1, s2, s3, is1, is2, fcode, l1, l2, st} = '0;
    {g1, b1, g2, b2, ofreq} = '0;
    zlev = 16'h0064;
    ibus = '0;
    ibus[47:32] = 16'h0800;
    ibus[63:48] = 16'h1000;
    reset_defaults;
    for (int i = 0; i < 15; i++) begin
      st = '0;
      pairs("code idle", dcode[i], {3{dcode[i] == 8'h1B}});
      st[dbit[i]] = 1'b1;
      pairs("code active", dcode[i], {3{dcode[i] != 8'h1B}});
    end
    $display("test code table done");
    st = 18'h0_0004;
    pairs("run2 output", 8'h37, 3'b111);
    st = 18'h0_000C;
    pairs("run2 injection", 8'h37, 3'b000);
    st = 18'h0_0084;
    pairs("run2 blocked", 8'h37, 3'b000);
    st = '0;
    ofreq = 16'h0063;
    pairs("zero below", 8'h01, 3'b111);
    ofreq = 16'h0064;
    pairs("zero equal", 8'h01, 3'b000);
    st = 18'h0_0420;
    pairs("ready with fault", 8'h06, 3'b000);
    st = 18'h0_0400;
    fcode = 8'h80;
    pairs("fault board a", 8'h0E, 3'b000);
    fcode = 8'h81;
    pairs("fault board b", 8'h0E, 3'b000);
    st = 18'h0_0800;
    pairs("fault minor only", 8'h0E, 3'b000);
    st = '1;
    foreach (dcode[i]) if (i < 4) pairs("undocumented", 8'h03 + 8'(i * 16'h0040), 3'b000);
    $display("test special codes done");
    for (int i = 0; i < 8; i++) begin
      ibus[16*at[i][0] +: 16] = at[i][1][15:0];
      {is1, is2} = {2{at[i][0][7:0]}};
      {g1, g2} = {2{at[i][2][15:0]}};
      {b1, b2} = {2{at[i][3][15:0]}};
      {l1, l2} = {2{at[i][4][1:0]}};
      load;
      settle;
      chk("analog one", a1s, exp_an(at[i][1], at[i][2], at[i][3], at[i][4]));
      chk("analog two", a2s, exp_an(at[i][1], at[i][2], at[i][3], at[i][4]));
    end
    $display("test analog scaling done");
    reset_defaults;
    test_done;
  end
endmodule : tb_status_output_selector
`default_nettype wire
